// *** hw/ocs_defines.vh ***
// constants for the output channel clock select block
`ifndef OCS_DEFINES_VH
`define OCS_DEFINES_VH

// register indices; byte address is four times the index
`define OCS_CTL_IDX      8'h25
`define OCS_DIV_IDX      8'h26
`define OCS_STAT_IDX     8'h27
`define OCS_IDX_HI       9
`define OCS_IDX_LO       2
`define OCS_ADDR_TOP     22'h000000
`define OCS_TOP_HI       31
`define OCS_TOP_LO       10
`define OCS_ALIGN_HI     1
`define OCS_ALIGN_OK     2'h0
`define OCS_REG_HI       7

// control register fields
`define OCS_SRC_HI       7
`define OCS_SRC_LO       6
`define OCS_FMT_HI       5
`define OCS_FMT_LO       4
`define OCS_MA_HI        3
`define OCS_MA_LO        2
`define OCS_MB_HI        1
`define OCS_MB_LO        0

// reset values
`define OCS_CTL_RST      8'h18
`define OCS_DIV_RST      8'h02

// source select codes
`define OCS_SRC_SYN1     2'h0
`define OCS_SRC_SYN2     2'h1
`define OCS_SRC_PRI      2'h2
`define OCS_SRC_SEC      2'h3

// format codes
`define OCS_FMT_OFF      2'h0
`define OCS_FMT_ACDIFF   2'h1
`define OCS_FMT_HCSL     2'h2
`define OCS_FMT_CMOS     2'h3

// single-ended pin states
`define OCS_PIN_TRI      2'h0
`define OCS_PIN_LOW      2'h1
`define OCS_PIN_INV      2'h2
`define OCS_PIN_TRUE     2'h3

// synchroniser lanes
`define OCS_NSYNC        7
`define OCS_L_SYN1       0
`define OCS_L_SYN2       1
`define OCS_L_PRI        2
`define OCS_L_SEC        3
`define OCS_L_PRI2       4
`define OCS_L_SEC2       5
`define OCS_L_DBL        6

// ahb
`define OCS_HRESP_OKAY   1'b0
`define OCS_ZERO8        8'h00
`define OCS_ZERO24       24'h000000
`define OCS_ONE8         8'h01
`define OCS_ZERO3        3'h0

`endif

// *** hw/ocs_channel.v ***
// output channel clock select, divider and driver control with ahb-lite registers
//
// Operation
// - bits 7:6 pick synthesizer one, synthesizer two, primary or secondary reference; reset 0.
// - with doubler on, reference selections deliver the doubled reference clock.
// - a reference selection bypasses the output divider entirely.
// - bits 5:4 choose off, ac differential, hcsl or cmos; reset 1.
// - differential formats: bits 3:2 set tail current code; reset 2.
// - cmos: bits 3:2 set positive pin tri, low, inverted or true.
// - hcsl: bits 1:0 set load termination code; reset 0.
// - cmos: bits 1:0 set negative pin with the same four states.
// - 8-bit divider, ratio is value plus one, 1 to 256; reset 0x02.
// - divider acts only on synthesizer sources, never on a reference.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`include "ocs_defines.vh"
`default_nettype none

module ocs_channel (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        clk_en,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output reg  [31:0] hrdata,
    output wire        hresp,
    input  wire        first_synthesizer,
    input  wire        second_synthesizer,
    input  wire        pri_ref_clk,
    input  wire        sec_ref_clk,
    input  wire        pri_ref_x2_clk,
    input  wire        sec_ref_x2_clk,
    input  wire        doubler_en,
    output reg         chan_clk_q,
    output reg         diff_clk_q,
    output reg         diff_en_q,
    output reg  [1:0]  drv_format_q,
    output reg  [1:0]  tail_sel_q,
    output reg  [1:0]  load_sel_q,
    output reg         out_p_q,
    output reg         out_p_oe_q,
    output reg         out_n_q,
    output reg         out_n_oe_q
);

    // register state
    reg  [7:0]  ctl_q;
    reg  [7:0]  ctl_d;
    reg  [7:0]  div_q;
    reg  [7:0]  div_d;

    // ahb data-phase capture
    reg         wr_pend_q;
    reg  [7:0]  wr_idx_q;
    reg         rd_sel;
    reg  [7:0]  rd_idx;
    reg  [31:0] hrdata_d;

    // synchroniser and clock path
    wire [`OCS_NSYNC-1:0] raw_in;
    reg  [`OCS_NSYNC-1:0] sync1_q;
    reg  [`OCS_NSYNC-1:0] sync2_q;
    reg         src_prev_q;
    reg  [7:0]  cnt_q;
    reg  [7:0]  cnt_d;
    reg         div_clk_q;
    reg         div_clk_d;

    wire [1:0]  src_sel;
    wire [1:0]  fmt_sel;
    wire [1:0]  mode_a;
    wire [1:0]  mode_b;
    wire        dbl_on;
    wire        is_ref;
    wire        src_lvl;
    wire        src_rise;
    wire [7:0]  half;
    wire        clk_sel;
    wire [7:0]  stat_val;

    // next values for the driver outputs
    reg         chan_clk_d;
    reg         diff_clk_d;
    reg         diff_en_d;
    reg  [1:0]  tail_sel_d;
    reg  [1:0]  load_sel_d;
    reg         out_p_d;
    reg         out_p_oe_d;
    reg         out_n_d;
    reg         out_n_oe_d;

    assign raw_in[`OCS_L_SYN1] = first_synthesizer;
    assign raw_in[`OCS_L_SYN2] = second_synthesizer;
    assign raw_in[`OCS_L_PRI]  = pri_ref_clk;
    assign raw_in[`OCS_L_SEC]  = sec_ref_clk;
    assign raw_in[`OCS_L_PRI2] = pri_ref_x2_clk;
    assign raw_in[`OCS_L_SEC2] = sec_ref_x2_clk;
    assign raw_in[`OCS_L_DBL]  = doubler_en;

    // no wait states, but a frozen block must stall the bus so no write is lost
    assign hreadyout = clk_en;
    assign hresp     = `OCS_HRESP_OKAY;

    // ---------------- bus slave ----------------

    // address phase decode: only aligned words at the mapped indices answer
    always @* begin
        rd_sel = 1'b0;
        rd_idx = haddr[`OCS_IDX_HI:`OCS_IDX_LO];
        if (hsel && hready && htrans[1] && !hwrite) begin
            rd_sel = 1'b1;
        end
    end

    // write lands in the data phase
    always @* begin
        ctl_d = ctl_q;
        div_d = div_q;
        if (wr_pend_q) begin
            if (wr_idx_q == `OCS_CTL_IDX) begin
                ctl_d = hwdata[`OCS_REG_HI:0];
            end
            if (wr_idx_q == `OCS_DIV_IDX) begin
                div_d = hwdata[`OCS_REG_HI:0];
            end
        end
    end

    // status: format active, reference selected, doubled reference in use, source
    assign stat_val = {`OCS_ZERO3, src_sel, dbl_on && is_ref, is_ref, fmt_sel != `OCS_FMT_OFF};

    // read data uses next register values so a write then read sees new data
    always @* begin
        hrdata_d = hrdata;
        if (rd_sel) begin
            hrdata_d = {`OCS_ZERO24, `OCS_ZERO8};
            if ((haddr[`OCS_TOP_HI:`OCS_TOP_LO] == `OCS_ADDR_TOP) &&
                (haddr[`OCS_ALIGN_HI:0] == `OCS_ALIGN_OK)) begin
                case (rd_idx)
                    `OCS_CTL_IDX: begin
                        hrdata_d = {`OCS_ZERO24, ctl_d};
                    end
                    `OCS_DIV_IDX: begin
                        hrdata_d = {`OCS_ZERO24, div_d};
                    end
                    `OCS_STAT_IDX: begin
                        hrdata_d = {`OCS_ZERO24, stat_val};
                    end
                    default: begin
                        hrdata_d = {`OCS_ZERO24, `OCS_ZERO8};
                    end
                endcase
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_q     <= `OCS_CTL_RST;
            div_q     <= `OCS_DIV_RST;
            wr_pend_q <= 1'b0;
            wr_idx_q  <= `OCS_ZERO8;
            hrdata    <= {`OCS_ZERO24, `OCS_ZERO8};
        end else if (clk_en) begin
            ctl_q     <= ctl_d;
            div_q     <= div_d;
            hrdata    <= hrdata_d;
            wr_pend_q <= 1'b0;
            if (hsel && hready && htrans[1] && hwrite &&
                (haddr[`OCS_TOP_HI:`OCS_TOP_LO] == `OCS_ADDR_TOP) &&
                (haddr[`OCS_ALIGN_HI:0] == `OCS_ALIGN_OK)) begin
                wr_pend_q <= 1'b1;
                wr_idx_q  <= haddr[`OCS_IDX_HI:`OCS_IDX_LO];
            end
        end
    end

    // ---------------- input synchronisers ----------------

    // clocks arrive from other domains; sampled, so only slow sources are faithful
    genvar gi;
    generate
        for (gi = 0; gi < `OCS_NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else if (clk_en) begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // ---------------- source mux and divider ----------------

    assign src_sel = ctl_q[`OCS_SRC_HI:`OCS_SRC_LO];
    assign fmt_sel = ctl_q[`OCS_FMT_HI:`OCS_FMT_LO];
    assign mode_a  = ctl_q[`OCS_MA_HI:`OCS_MA_LO];
    assign mode_b  = ctl_q[`OCS_MB_HI:`OCS_MB_LO];
    assign dbl_on  = sync2_q[`OCS_L_DBL];
    assign is_ref  = (src_sel == `OCS_SRC_PRI) || (src_sel == `OCS_SRC_SEC);

    assign src_lvl = (src_sel == `OCS_SRC_SYN1) ? sync2_q[`OCS_L_SYN1] :
                     (src_sel == `OCS_SRC_SYN2) ? sync2_q[`OCS_L_SYN2] :
                     (src_sel == `OCS_SRC_PRI)  ? (dbl_on ? sync2_q[`OCS_L_PRI2] : sync2_q[`OCS_L_PRI]) :
                                                  (dbl_on ? sync2_q[`OCS_L_SEC2] : sync2_q[`OCS_L_SEC]);

    assign src_rise = src_lvl && !src_prev_q;

    // high for the first half of each period; odd ratios sit low one edge longer
    assign half = ({1'b0, div_q[7:1]}) + {7'h00, div_q[0]};

    // counter wraps at the field value: ratio is value plus one
    always @* begin
        cnt_d     = cnt_q;
        div_clk_d = div_clk_q;
        if (src_rise) begin
            if (cnt_q >= div_q) begin
                cnt_d = `OCS_ZERO8;
            end else begin
                cnt_d = cnt_q + `OCS_ONE8;
            end
            div_clk_d = (cnt_d < half);
        end
    end

    // ratio one and reference sources pass the level straight through
    assign clk_sel = (is_ref || (div_q == `OCS_ZERO8)) ? src_lvl : div_clk_q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_prev_q <= 1'b0;
            cnt_q      <= `OCS_ZERO8;
            div_clk_q  <= 1'b0;
        end else if (clk_en) begin
            src_prev_q <= src_lvl;
            if (is_ref) begin
                cnt_q     <= `OCS_ZERO8;
                div_clk_q <= 1'b0;
            end else begin
                cnt_q     <= cnt_d;
                div_clk_q <= div_clk_d;
            end
        end
    end

    // ---------------- output driver control ----------------

    always @* begin
        chan_clk_d = 1'b0;
        diff_clk_d = 1'b0;
        diff_en_d  = 1'b0;
        tail_sel_d = 2'h0;
        load_sel_d = 2'h0;
        out_p_d    = 1'b0;
        out_p_oe_d = 1'b0;
        out_n_d    = 1'b0;
        out_n_oe_d = 1'b0;
        case (fmt_sel)
            `OCS_FMT_OFF: begin
                chan_clk_d = 1'b0;
            end
            `OCS_FMT_ACDIFF: begin
                chan_clk_d = clk_sel;
                diff_clk_d = clk_sel;
                diff_en_d  = 1'b1;
                tail_sel_d = mode_a;
            end
            `OCS_FMT_HCSL: begin
                chan_clk_d = clk_sel;
                diff_clk_d = clk_sel;
                diff_en_d  = 1'b1;
                tail_sel_d = mode_a;
                load_sel_d = mode_b;
            end
            `OCS_FMT_CMOS: begin
                chan_clk_d = clk_sel;
                case (mode_a)
                    `OCS_PIN_TRI: begin
                        out_p_oe_d = 1'b0;
                    end
                    `OCS_PIN_LOW: begin
                        out_p_oe_d = 1'b1;
                    end
                    `OCS_PIN_INV: begin
                        out_p_oe_d = 1'b1;
                        out_p_d    = !clk_sel;
                    end
                    default: begin
                        out_p_oe_d = 1'b1;
                        out_p_d    = clk_sel;
                    end
                endcase
                case (mode_b)
                    `OCS_PIN_TRI: begin
                        out_n_oe_d = 1'b0;
                    end
                    `OCS_PIN_LOW: begin
                        out_n_oe_d = 1'b1;
                    end
                    `OCS_PIN_INV: begin
                        out_n_oe_d = 1'b1;
                        out_n_d    = !clk_sel;
                    end
                    default: begin
                        out_n_oe_d = 1'b1;
                        out_n_d    = clk_sel;
                    end
                endcase
            end
            default: begin
                chan_clk_d = 1'b0;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_clk_q   <= 1'b0;
            diff_clk_q   <= 1'b0;
            diff_en_q    <= 1'b0;
            drv_format_q <= 2'h0;
            tail_sel_q   <= 2'h0;
            load_sel_q   <= 2'h0;
            out_p_q      <= 1'b0;
            out_p_oe_q   <= 1'b0;
            out_n_q      <= 1'b0;
            out_n_oe_q   <= 1'b0;
        end else if (clk_en) begin
            chan_clk_q   <= chan_clk_d;
            diff_clk_q   <= diff_clk_d;
            diff_en_q    <= diff_en_d;
            drv_format_q <= fmt_sel;
            tail_sel_q   <= tail_sel_d;
            load_sel_q   <= load_sel_d;
            out_p_q      <= out_p_d;
            out_p_oe_q   <= out_p_oe_d;
            out_n_q      <= out_n_d;
            out_n_oe_q   <= out_n_oe_d;
        end
    end

endmodule // ocs_channel

`default_nettype wire

// *** test/ocs_channel_assertions.sv ***
// concurrent checks on the output channel select ports
`timescale 1ns/1ps
`default_nettype none
module ocs_channel_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        clk_en,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hreadyout,
    input wire logic        chan_clk_q,
    input wire logic        diff_clk_q,
    input wire logic        diff_en_q,
    input wire logic [1:0]  drv_format_q,
    input wire logic [1:0]  tail_sel_q,
    input wire logic [1:0]  load_sel_q,
    input wire logic        out_p_oe_q,
    input wire logic        out_n_oe_q
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // write to control taken on this edge
    wire wr_ctl = hsel && hreadyout && htrans[1] && hwrite && haddr == 32'h94 && clk_en;

    off_silent_a: assert property (drv_format_q == 2'h0 [*2] |->
        !chan_clk_q && !diff_en_q && !out_p_oe_q && !out_n_oe_q) else $error("output active with format off");
    diff_enable_a: assert property (diff_en_q == (drv_format_q == 2'h1 || drv_format_q == 2'h2))
        else $error("differential enable wrong for format");
    cmos_pins_a: assert property (drv_format_q != 2'h3 |-> !out_p_oe_q && !out_n_oe_q)
        else $error("single ended pin driven outside cmos");
    load_sel_a: assert property (drv_format_q != 2'h2 |-> load_sel_q == 2'h0)
        else $error("load select set outside hcsl");
    tail_sel_a: assert property (!diff_en_q |-> tail_sel_q == 2'h0)
        else $error("tail select set outside differential");
    diff_clk_a: assert property (!diff_en_q [*2] |-> !diff_clk_q)
        else $error("differential clock with driver off");
    ctl_write_a: assert property (wr_ctl ##1 clk_en [*3] |-> drv_format_q == $past(hwdata[5:4], 2))
        else $error("format not taken from control write");
    reset_fmt_a: assert property ($rose(hresetn) && clk_en |=> drv_format_q == 2'h1 && tail_sel_q == 2'h2)
        else $error("driver reset state wrong");
endmodule // ocs_channel_checker

bind ocs_channel ocs_channel_checker i_chk (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout),
    .chan_clk_q(chan_clk_q), .diff_clk_q(diff_clk_q), .diff_en_q(diff_en_q), .drv_format_q(drv_format_q),
    .tail_sel_q(tail_sel_q), .load_sel_q(load_sel_q), .out_p_oe_q(out_p_oe_q), .out_n_oe_q(out_n_oe_q));
`default_nettype wire

// *** test/ocs_channel_test.sv ***
// self-checking bench for the output channel select block
`timescale 1ns/1ps
`include "ocs_defines.vh"
`default_nettype none
module ocs_channel_test;
    localparam logic [31:0] A_CTL  = {22'h0, `OCS_CTL_IDX, 2'b00};
    localparam logic [31:0] A_DIV  = {22'h0, `OCS_DIV_IDX, 2'b00};
    localparam logic [31:0] A_STAT = {22'h0, `OCS_STAT_IDX, 2'b00};
    logic        hclk, hresetn, clk_en, hsel, hwrite, doubler_en, d, cp, ap;
    logic [31:0] haddr, hwdata, rd, seed;
    logic [1:0]  htrans, s, f;
    logic [2:0]  hsize;
    logic [7:0]  dv;
    logic [5:0]  src;
    wire         hready, hresp, chan_clk_q, diff_clk_q, diff_en_q, out_p_q, out_p_oe_q, out_n_q, out_n_oe_q;
    wire  [31:0] hrdata;
    wire  [1:0]  drv_format_q, tail_sel_q, load_sel_q;
    wire         ax = drv_format_q == `OCS_FMT_CMOS ? out_n_q : diff_clk_q;
    int          err_count, checked, cyc, r, p, e, n1, n2;
    // src, doubler, format, divider
    logic [12:0] tab [9] = '{{2'd0, 1'b0, 2'd3, 8'd0}, {2'd0, 1'b0, 2'd1, 8'd2}, {2'd1, 1'b0, 2'd2, 8'd3},
        {2'd0, 1'b0, 2'd3, 8'd255}, {2'd2, 1'b0, 2'd3, 8'd5}, {2'd3, 1'b0, 2'd1, 8'd7},
        {2'd2, 1'b1, 2'd3, 8'd0}, {2'd3, 1'b1, 2'd2, 8'd4}, {2'd1, 1'b0, 2'd0, 8'd9}};

    ocs_channel i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .first_synthesizer(src[0]),
        .second_synthesizer(src[1]), .pri_ref_clk(src[2]), .sec_ref_clk(src[3]), .pri_ref_x2_clk(src[4]),
        .sec_ref_x2_clk(src[5]), .doubler_en(doubler_en), .chan_clk_q(chan_clk_q), .diff_clk_q(diff_clk_q),
        .diff_en_q(diff_en_q), .drv_format_q(drv_format_q), .tail_sel_q(tail_sel_q), .load_sel_q(load_sel_q),
        .out_p_q(out_p_q), .out_p_oe_q(out_p_oe_q), .out_n_q(out_n_q), .out_n_oe_q(out_n_oe_q));

    function automatic logic tg(input int c, input int h);
        return (c / h) % 2 != 0;
    endfunction
    // source clocks well below half of hclk so the synchronisers see every edge
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        src <= {tg(cyc, 9), tg(cyc, 7), tg(cyc, 6), tg(cyc, 5), tg(cyc, 4), tg(cyc, 3)};
    end
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    function automatic int half(input logic [1:0] sv, input logic dd);
        return sv == 0 ? 3 : sv == 1 ? 4 : sv == 2 ? (dd ? 7 : 5) : (dd ? 9 : 6);
    endfunction
    function automatic logic near(input int n, input int ev);
        return ev == 0 ? n == 0 : n >= ev - 1 && n <= ev + 1;
    endfunction
    function automatic logic [8:0] drv_exp(input logic [1:0] fm, input logic [1:0] ma, input logic [1:0] mb);
        logic df;
        df = fm == `OCS_FMT_ACDIFF || fm == `OCS_FMT_HCSL;
        return {fm, df, df ? ma : 2'h0, fm == `OCS_FMT_HCSL ? mb : 2'h0,
            fm == `OCS_FMT_CMOS && ma != 0, fm == `OCS_FMT_CMOS && mb != 0};
    endfunction

    task stop_test;
        if (err_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            err_count++;
            stop_test;
        end
    endtask
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
        rd = hrdata;
    endtask

    initial begin
        {hresetn, hsel, hwrite, doubler_en, haddr, hwdata, htrans} = '0;
        {err_count, checked} = '0;
        clk_en = 1'b1;
        hsize = 3'h2;
        seed = 32'hd77022d5;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(0, A_CTL, 32'h0);
        chk(rd, {24'h0, `OCS_CTL_RST}, "control reset");
        ahb(0, A_DIV, 32'h0);
        chk(rd, {24'h0, `OCS_DIV_RST}, "divider reset");
        chk({drv_format_q, diff_en_q, tail_sel_q, load_sel_q}, {2'h1, 1'b1, 2'h2, 2'h0}, "reset pins");
        for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            ahb(1, A_DIV, seed);
            ahb(1, A_CTL, seed >> 8);
            ahb(0, A_DIV, 32'h0);
            chk(rd, {24'h0, seed[7:0]}, "divider");
            ahb(0, A_CTL, 32'h0);
            chk(rd, {24'h0, seed[15:8]}, "control");
        end
        // unmapped place: write ignored, read gives zero
        ahb(1, A_CTL | 32'h400, 32'hff);
        ahb(0, A_CTL | 32'h400, 32'h0);
        chk(rd, 32'h0, "unmapped");
        ahb(0, A_CTL | 32'h1, 32'h0);
        chk(rd, 32'h0, "misaligned");
        chk(hresp, 1'b0, "response");
        ahb(0, A_CTL, 32'h0);
        chk(rd, {24'h0, seed[15:8]}, "control kept");
        clk_en <= 1'b0;
        repeat (2) @(posedge hclk);
        chk(hready, 1'b0, "stall ready");
        clk_en <= 1'b1;
        @(posedge hclk);
        for (int k = 0; k < 64; k++) begin
            ahb(1, A_CTL, {26'h0, k[5:0]});
            repeat (3) @(posedge hclk);
            chk({drv_format_q, diff_en_q, tail_sel_q, load_sel_q, out_p_oe_q, out_n_oe_q},
                drv_exp(k[5:4], k[3:2], k[1:0]), "driver");
            // tri and held-low pins must never show the clock
            chk({out_p_q && !(k[5:4] == 3 && k[3]), out_n_q && !(k[5:4] == 3 && k[1])},
                2'h0, "pin low");
        end
        for (int i = 0; i < 9; i++) begin
            {s, d, f, dv} = tab[i];
            doubler_en <= d;
            ahb(1, A_DIV, {24'h0, dv});
            ahb(1, A_CTL, {24'h0, s, f, 4'he});
            r = s[1] ? 1 : dv + 1;
            p = 2 * half(s, d);
            e = f == 0 ? 0 : 8;
            // let synchronisers and divider phase settle before counting
            repeat (p * r * 2 + 10) @(posedge hclk);
            ahb(0, A_STAT, 32'h0);
            chk(rd, {27'h0, s, d && s[1], s[1], f != 2'h0}, "status");
            n1 = 0;
            n2 = 0;
            cp = chan_clk_q;
            ap = ax;
            repeat (p * r * 8) begin
                @(posedge hclk);
                n1 += chan_clk_q && !cp;
                n2 += ax && !ap;
                cp = chan_clk_q;
                ap = ax;
                // positive pin true polarity, negative pin inverted
                if (f == `OCS_FMT_CMOS) begin
                    chk({out_p_q, out_n_q}, {chan_clk_q, !chan_clk_q}, "pin polarity");
                end
            end
            chk(near(n1, e), 1'b1, "channel edges");
            chk(near(n2, e), 1'b1, "pin edges");
        end
        // second reset in mid run: registers return to their reset values
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(0, A_CTL, 32'h0);
        chk(rd, {24'h0, `OCS_CTL_RST}, "control after reset");
        ahb(0, A_DIV, 32'h0);
        chk(rd, {24'h0, `OCS_DIV_RST}, "divider after reset");
        stop_test;
    end
endmodule // ocs_channel_test
`default_nettype wire
